// File: hw/stm_regs.svh
// register offsets, field positions, reset values and counts of the timer
// assumes an 8-bit byte address on a 32-bit AXI4-Lite register bus
`ifndef STM_REGS_SVH
`define STM_REGS_SVH

`define STM_OFS_CTRL_A 8'h00
`define STM_OFS_CTRL_B 8'h04
`define STM_OFS_CNT_LO 8'h08
`define STM_OFS_CNT_HI 8'h0C
`define STM_OFS_CMPA_LO 8'h10
`define STM_OFS_CMPA_HI 8'h14
`define STM_OFS_CMPP 8'h18
`define STM_OFS_STATUS 8'h1C
`define STM_LAST_INDEX 6'h07

`define STM_A_PAUSE 7
`define STM_A_CLK_HI 6
`define STM_A_CLK_LO 4
`define STM_A_ON 3
`define STM_A_WMASK 8'hF8

`define STM_B_MODE_HI 7
`define STM_B_MODE_LO 6
`define STM_B_ACT_HI 5
`define STM_B_ACT_LO 4
`define STM_B_INIT 3
`define STM_B_INV 2
`define STM_B_SWAP 1
`define STM_B_CLRA 0

`define STM_S_FLAG_A 0
`define STM_S_FLAG_P 1

`define STM_RESET_BYTE 8'h00
`define STM_RESP_OKAY 2'h0
`define STM_RESP_SLVERR 2'h2

`define STM_DIV4_ALL 2'h3
`define STM_DIV16_ALL 4'hF
`define STM_DIV64_ALL 6'h3F
`define STM_FULL_SPAN 17'h1_0000

`endif

// File: hw/stm_pkg.sv
// types shared by the standard timer design
// assumes stm_regs.svh for the numeric constants
package stm_pkg;

    typedef enum logic [1:0] {
        STM_MODE_CMP = 2'b00,
        STM_MODE_UNDEF = 2'b01,
        STM_MODE_PWM = 2'b10,
        STM_MODE_TMR = 2'b11
    } stm_mode_t;

    typedef enum logic [2:0] {
        STM_CK_SYS4 = 3'b000,
        STM_CK_SYS = 3'b001,
        STM_CK_HS16 = 3'b010,
        STM_CK_HS64 = 3'b011,
        STM_CK_SUB0 = 3'b100,
        STM_CK_SUB1 = 3'b101,
        STM_CK_EXTR = 3'b110,
        STM_CK_EXTF = 3'b111
    } stm_clk_t;

    typedef enum logic [1:0] {
        STM_ACT_A = 2'b00,
        STM_ACT_B = 2'b01,
        STM_ACT_C = 2'b10,
        STM_ACT_D = 2'b11
    } stm_act_t;

    typedef struct packed {
        logic [7:0] ctrlA;
        logic [7:0] ctrlB;
        logic [15:0] cmpA;
        logic [7:0] cmpP;
        logic [15:0] cnt;
        logic prevOn;
        logic level;
        logic pulse;
        logic flagA;
        logic flagP;
        logic [5:0] pre;
        logic [2:0] extSync;
        logic extLvl;
        logic [2:0] subSync;
        logic subLvl;
        logic pin;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } stm_state_t;

endpackage

// File: hw/stm_timer.sv
// standard timer: 16-bit counter, comparators A and P, one output pin
// assumes ref_clk as system and high-speed clock, pins asynchronous
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stm_regs.svh"

module stm_timer
    import stm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic extCountPin,
    input wire logic subClockPin,
    output logic timerOutputPin
);

    stm_state_t st;
    stm_state_t next_st;

    logic onBit;
    logic pauseBit;
    logic onRise;
    logic extNew;
    logic subNew;
    logic tick;
    logic countEn;
    logic [16:0] nxt;
    logic matchA;
    logic matchP;
    logic periodHit;
    logic setA;
    logic setP;
    logic [16:0] dutyVal;
    logic pwmActive;
    logic doWrite;
    stm_mode_t mode;
    stm_act_t act;
    stm_clk_t clkSel;

    function automatic logic regMapped(input logic [7:0] addr);
        regMapped = addr[7:2] <= `STM_LAST_INDEX;
    endfunction

    assign mode = stm_mode_t'(st.ctrlB[`STM_B_MODE_HI:`STM_B_MODE_LO]);
    assign act = stm_act_t'(st.ctrlB[`STM_B_ACT_HI:`STM_B_ACT_LO]);
    assign clkSel = stm_clk_t'(st.ctrlA[`STM_A_CLK_HI:`STM_A_CLK_LO]);
    assign onBit = st.ctrlA[`STM_A_ON];
    assign pauseBit = st.ctrlA[`STM_A_PAUSE];
    assign onRise = onBit & ~st.prevOn;

    // filtered pin levels: move once second and third stages agree
    assign extNew = (st.extSync[1] == st.extSync[2]) ?
        st.extSync[2] : st.extLvl;
    assign subNew = (st.subSync[1] == st.subSync[2]) ?
        st.subSync[2] : st.subLvl;

    always_comb begin
        case (clkSel)
            STM_CK_SYS4: tick = st.pre[1:0] == `STM_DIV4_ALL;
            STM_CK_SYS: tick = 1'b1;
            STM_CK_HS16: tick = st.pre[3:0] == `STM_DIV16_ALL;
            STM_CK_HS64: tick = st.pre == `STM_DIV64_ALL;
            STM_CK_SUB0: tick = subNew & ~st.subLvl;
            STM_CK_SUB1: tick = subNew & ~st.subLvl;
            STM_CK_EXTR: tick = extNew & ~st.extLvl;
            STM_CK_EXTF: tick = ~extNew & st.extLvl;
            default: tick = 1'b0;
        endcase
    end

    // counting needs the timer on, not paused, and a source tick
    assign countEn = onBit & st.prevOn & ~pauseBit & tick;
    assign nxt = {1'b0, st.cnt} + 17'h0_0001;

    // comparators judge the value the counter is about to take
    assign matchA = nxt == {1'b0, st.cmpA};
    assign matchP = (st.cmpP == 8'h00) ? nxt[16] :
        (nxt[15:0] == {st.cmpP, 8'h00});

    always_comb begin
        if (mode == STM_MODE_PWM) begin
            periodHit = st.ctrlB[`STM_B_SWAP] ? matchA : matchP;
        end else begin
            periodHit = st.ctrlB[`STM_B_CLRA] ? matchA : matchP;
        end
    end

    assign setA = countEn & matchA;
    assign setP = countEn & matchP &
        ((mode == STM_MODE_PWM) | ~st.ctrlB[`STM_B_CLRA]);

    always_comb begin
        if (st.ctrlB[`STM_B_SWAP]) begin
            dutyVal = (st.cmpP == 8'h00) ? `STM_FULL_SPAN :
                {1'b0, st.cmpP, 8'h00};
        end else begin
            dutyVal = {1'b0, st.cmpA};
        end
    end

    // duty at or above the period keeps the output active throughout
    assign pwmActive = {1'b0, st.cnt} < dutyVal;
    assign doWrite = st.awHeld & st.wHeld & ~st.bvalid;

    assign awready = ~st.awHeld & ~st.bvalid;
    assign wready = ~st.wHeld & ~st.bvalid;
    assign arready = ~st.rvalid;

    always_comb begin
        logic lv;
        lv = 1'b0;
        next_st = st;
        next_st.pre = st.pre + 6'h01;
        next_st.extSync = {st.extSync[1:0], extCountPin};
        next_st.subSync = {st.subSync[1:0], subClockPin};
        next_st.extLvl = extNew;
        next_st.subLvl = subNew;
        next_st.prevOn = onBit;

        // write channel capture, in either order
        if (awvalid & awready) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = awaddr;
        end
        if (wvalid & wready) begin
            next_st.wHeld = 1'b1;
            next_st.wData = wdata;
            next_st.wStrb = wstrb;
        end
        if (st.bvalid & bready) begin
            next_st.bvalid = 1'b0;
        end
        if (doWrite) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = regMapped(st.awAddr) ?
                `STM_RESP_OKAY : `STM_RESP_SLVERR;
            if (regMapped(st.awAddr) & st.wStrb[0]) begin
                case ({2'b00, st.awAddr[7:2]})
                    `STM_OFS_CTRL_A >> 2:
                        next_st.ctrlA = st.wData[7:0] & `STM_A_WMASK;
                    `STM_OFS_CTRL_B >> 2:
                        next_st.ctrlB = st.wData[7:0];
                    `STM_OFS_CMPA_LO >> 2:
                        next_st.cmpA[7:0] = st.wData[7:0];
                    `STM_OFS_CMPA_HI >> 2:
                        next_st.cmpA[15:8] = st.wData[7:0];
                    `STM_OFS_CMPP >> 2:
                        next_st.cmpP = st.wData[7:0];
                    `STM_OFS_STATUS >> 2: begin
                        next_st.flagA = st.flagA & ~st.wData[`STM_S_FLAG_A];
                        next_st.flagP = st.flagP & ~st.wData[`STM_S_FLAG_P];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // read channel
        if (st.rvalid & rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid & arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = regMapped(araddr) ?
                `STM_RESP_OKAY : `STM_RESP_SLVERR;
            next_st.rdata = 32'h0000_0000;
            case ({2'b00, araddr[7:2]})
                `STM_OFS_CTRL_A >> 2: next_st.rdata[7:0] = st.ctrlA;
                `STM_OFS_CTRL_B >> 2: next_st.rdata[7:0] = st.ctrlB;
                `STM_OFS_CNT_LO >> 2: next_st.rdata[7:0] = st.cnt[7:0];
                `STM_OFS_CNT_HI >> 2: next_st.rdata[7:0] = st.cnt[15:8];
                `STM_OFS_CMPA_LO >> 2: next_st.rdata[7:0] = st.cmpA[7:0];
                `STM_OFS_CMPA_HI >> 2: next_st.rdata[7:0] = st.cmpA[15:8];
                `STM_OFS_CMPP >> 2: next_st.rdata[7:0] = st.cmpP;
                `STM_OFS_STATUS >> 2: begin
                    next_st.rdata[`STM_S_FLAG_A] = st.flagA;
                    next_st.rdata[`STM_S_FLAG_P] = st.flagP;
                end
                default: begin
                end
            endcase
        end

        // counter
        if (onRise) begin
            next_st.cnt = 16'h0000;
        end else if (countEn) begin
            next_st.cnt = periodHit ? 16'h0000 : nxt[15:0];
        end

        // flags: a set in the same cycle as a clear wins
        if (setA) begin
            next_st.flagA = 1'b1;
        end
        if (setP) begin
            next_st.flagP = 1'b1;
        end

        // compare output level
        if (onRise) begin
            next_st.level = st.ctrlB[`STM_B_INIT];
        end else if (mode == STM_MODE_CMP && setA) begin
            case (act)
                STM_ACT_B: next_st.level = 1'b0;
                STM_ACT_C: next_st.level = 1'b1;
                STM_ACT_D: next_st.level = ~st.level;
                default: next_st.level = st.level;
            endcase
        end

        // single pulse: active from start until the duty point
        if (onRise) begin
            next_st.pulse = 1'b1;
        end else if (countEn && nxt == dutyVal) begin
            next_st.pulse = 1'b0;
        end

        case (mode)
            STM_MODE_CMP: lv = next_st.level;
            STM_MODE_PWM: begin
                case (act)
                    STM_ACT_A: lv = ~st.ctrlB[`STM_B_INIT];
                    STM_ACT_B: lv = st.ctrlB[`STM_B_INIT];
                    STM_ACT_C: lv = pwmActive ?
                        st.ctrlB[`STM_B_INIT] : ~st.ctrlB[`STM_B_INIT];
                    default: lv = next_st.pulse ?
                        st.ctrlB[`STM_B_INIT] : ~st.ctrlB[`STM_B_INIT];
                endcase
            end
            default: lv = 1'b0;
        endcase
        // timer mode and the undefined code leave the pin low
        if (mode == STM_MODE_CMP || mode == STM_MODE_PWM) begin
            next_st.pin = lv ^ st.ctrlB[`STM_B_INV];
        end else begin
            next_st.pin = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign timerOutputPin = st.pin;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_rise_clears;
        onRise |=> (st.cnt == 16'h0000) &&
            (mode != STM_MODE_CMP || st.level == $past(st.ctrlB[3]));
    endproperty
    a_rise_clears: assert property (p_rise_clears)
        else $error("counter or level not reset on start");

    property p_off_holds;
        !onBit |=> st.cnt == $past(st.cnt);
    endproperty
    a_off_holds: assert property (p_off_holds)
        else $error("counter moved while off");

    property p_pause_holds;
        (onBit && st.prevOn && pauseBit) [*2] |-> $stable(st.cnt);
    endproperty
    a_pause_holds: assert property (p_pause_holds)
        else $error("counter moved while paused");

    property p_count_step;
        countEn && !periodHit |=> st.cnt == $past(st.cnt) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not advance by one");

    property p_clear_on_a;
        countEn && matchA && st.ctrlB[0] && mode == STM_MODE_CMP
            |=> st.cnt == 16'h0000 && st.flagA;
    endproperty
    a_clear_on_a: assert property (p_clear_on_a)
        else $error("comparator A match did not clear");

    property p_no_p_flag;
        !st.flagP && st.ctrlB[0] && mode == STM_MODE_CMP
            && $stable(st.ctrlB) |=> !st.flagP;
    endproperty
    a_no_p_flag: assert property (p_no_p_flag)
        else $error("P flag raised while clearing on A");

    property p_drive_high;
        mode == STM_MODE_CMP && act == STM_ACT_C && setA && !onRise
            |=> st.level ##1 st.pin == !$past(st.ctrlB[2], 2);
    endproperty
    a_drive_high: assert property (p_drive_high)
        else $error("compare match did not drive the pin high");

    property p_forced_inactive;
        mode == STM_MODE_PWM && act == STM_ACT_A
            |=> st.pin == ($past(~st.ctrlB[3]) ^ $past(st.ctrlB[2]));
    endproperty
    a_forced_inactive: assert property (p_forced_inactive)
        else $error("forced inactive level wrong");

    property p_low_bits_zero;
        st.ctrlA[2:0] == 3'h0;
    endproperty
    a_low_bits_zero: assert property (p_low_bits_zero)
        else $error("unimplemented control bits not zero");

    property p_ext_edge;
        onBit && st.prevOn && !pauseBit && clkSel == STM_CK_EXTR
            && extNew && !st.extLvl |-> countEn;
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("external rising edge not counted");

endmodule
`default_nettype wire

// File: sim/stm_timer_bench.sv
// self-checking bench for the standard timer, registers over AXI4-Lite
// assumes stm_timer with stm_regs.svh offsets, 20 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "stm_regs.svh"

module stm_timer_bench
    import stm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic extCountPin = 1'b0;
    logic subClockPin = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid, timerOutputPin;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    logic [1:0] resp;
    logic [31:0] rdv;
    int err_total = 0;
    int samples_checked = 0;

    stm_timer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .extCountPin(extCountPin), .subClockPin(subClockPin),
        .timerOutputPin(timerOutputPin));

    always #25 ref_clk = ~ref_clk;

    // external pin: a rising edge every 8 cycles, sub clock every 16
    always begin
        repeat (4) @(posedge ref_clk);
        extCountPin <= ~extCountPin;
        repeat (4) @(posedge ref_clk);
        extCountPin <= ~extCountPin;
        subClockPin <= ~subClockPin;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, sa, sw;
        int n;
        begin
            @(posedge ref_clk);
            ta = 1'b0;
            tw = 1'b0;
            n = 0;
            awaddr <= a;
            wdata <= {24'h00_0000, d};
            wstrb <= 4'h1;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!(ta && tw) && n < 100) begin
                @(negedge ref_clk);
                sa = awvalid & awready;
                sw = wvalid & wready;
                @(posedge ref_clk);
                if (sa) begin
                    awvalid <= 1'b0;
                    ta = 1'b1;
                end
                if (sw) begin
                    wvalid <= 1'b0;
                    tw = 1'b1;
                end
                n++;
            end
            do begin
                @(negedge ref_clk);
                n++;
            end while (bvalid !== 1'b1 && n < 200);
            resp = bresp;
            @(posedge ref_clk);
            bready <= 1'b0;
            if (n >= 200) err_total++;
        end
    endtask

    task rd(input logic [7:0] a);
        int n;
        begin
            @(posedge ref_clk);
            n = 0;
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(negedge ref_clk);
                n++;
            end while (arready !== 1'b1 && n < 100);
            @(posedge ref_clk);
            arvalid <= 1'b0;
            do begin
                @(negedge ref_clk);
                n++;
            end while (rvalid !== 1'b1 && n < 200);
            rdv = rdata;
            resp = rresp;
            @(posedge ref_clk);
            rready <= 1'b0;
            if (n >= 200) err_total++;
        end
    endtask

    task rw(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        wr(a, d);
        chk(resp, `STM_RESP_OKAY);
        rd(a);
        chk(rdv, e);
    endtask

    // cycles until the output pin next changes, capped at lim
    task chg(output int c, input int lim);
        logic p;
        begin
            c = 0;
            @(negedge ref_clk);
            p = timerOutputPin;
            while (timerOutputPin === p && c < lim) begin
                @(negedge ref_clk);
                c++;
            end
        end
    endtask

    task start(input logic [7:0] b);
        wr(`STM_OFS_CTRL_A, 8'h00);
        wr(`STM_OFS_CTRL_B, b);
        wr(`STM_OFS_CTRL_A, 8'h18);
    endtask

    task lvl(input logic [7:0] b, input logic p0, input logic p1);
        int c;
        begin
            start(b);
            tick(2);
            @(negedge ref_clk);
            chk(timerOutputPin, p0);
            chg(c, 400);
            chk(timerOutputPin, p1);
        end
    endtask

    task duty(input logic [7:0] b, input int w, input int e);
        int i, h;
        begin
            start(b);
            tick(300);
            h = 0;
            for (i = 0; i < w; i++) begin
                @(negedge ref_clk);
                if (timerOutputPin === 1'b1) h++;
            end
            chk(h, e);
        end
    endtask

    task t_regs;
        int i;
        begin
            for (i = 0; i < 8; i++) begin
                rd(8'(i * 4));
                chk(rdv, 32'h0000_0000);
            end
            rw(`STM_OFS_CTRL_A, 8'hF7, 8'hF0);
            rw(`STM_OFS_CTRL_B, 8'hA5, 8'hA5);
            rw(`STM_OFS_CMPA_HI, 8'h5A, 8'h5A);
            rw(`STM_OFS_CMPP, 8'h3C, 8'h3C);
            rw(`STM_OFS_CNT_LO, 8'h55, 8'h00);
            wr(8'h20, 8'h01);
            chk(resp, `STM_RESP_SLVERR);
            rd(8'h20);
            chk(resp, `STM_RESP_SLVERR);
            chk(rdv, 32'h0000_0000);
            $display("register test done");
        end
    endtask

    task t_clk;
        int s, c;
        int dv [8];
        begin
            dv = '{4, 1, 16, 64, 16, 16, 8, 8};
            wr(`STM_OFS_CMPA_LO, 8'h04);
            wr(`STM_OFS_CMPA_HI, 8'h00);
            wr(`STM_OFS_CTRL_B, 8'h31);
            for (s = 0; s < 8; s++) begin
                wr(`STM_OFS_CTRL_A, 8'h00);
                wr(`STM_OFS_CTRL_A, {1'b0, 3'(s), 4'h8});
                chg(c, 600);
                chg(c, 600);
                chg(c, 600);
                chk(c + 1, 4 * dv[s]);
            end
            $display("clock select test done");
        end
    endtask

    task t_cnt;
        logic [7:0] a0;
        begin
            wr(`STM_OFS_CMPA_LO, 8'h00);
            start(8'hC1);
            tick(50);
            wr(`STM_OFS_CTRL_A, 8'h98);
            rd(`STM_OFS_CNT_LO);
            a0 = rdv[7:0];
            tick(20);
            rd(`STM_OFS_CNT_LO);
            chk(rdv, a0);
            wr(`STM_OFS_CTRL_A, 8'h18);
            tick(10);
            rd(`STM_OFS_CNT_LO);
            chk(rdv[7:0] > a0, 1'b1);
            wr(`STM_OFS_CTRL_A, 8'h10);
            rd(`STM_OFS_CNT_LO);
            a0 = rdv[7:0];
            tick(20);
            wr(`STM_OFS_CNT_LO, 8'h55);
            rd(`STM_OFS_CNT_LO);
            chk(rdv, a0);
            wr(`STM_OFS_CTRL_A, 8'h18);
            rd(`STM_OFS_CNT_LO);
            chk(rdv[7:0] < 8'h10, 1'b1);
            rd(`STM_OFS_CNT_HI);
            chk(rdv, 32'h0000_0000);
            $display("counter control test done");
        end
    endtask

    task t_out;
        int c;
        begin
            wr(`STM_OFS_CMPA_LO, 8'hC8);
            lvl(8'h21, 1'b0, 1'b1);
            lvl(8'h19, 1'b1, 1'b0);
            lvl(8'h19, 1'b1, 1'b0);
            lvl(8'h39, 1'b1, 1'b0);
            lvl(8'h09, 1'b1, 1'b1);
            lvl(8'h1D, 1'b0, 1'b1);
            lvl(8'hCD, 1'b0, 1'b0);
            lvl(8'h4D, 1'b0, 1'b0);
            lvl(8'h89, 1'b0, 1'b0);
            lvl(8'h99, 1'b1, 1'b1);
            wr(`STM_OFS_CMPP, 8'h01);
            wr(`STM_OFS_CMPA_LO, 8'h40);
            duty(8'hA9, 512, 128);
            duty(8'hAD, 512, 384);
            lvl(8'hB8, 1'b1, 1'b0);
            chg(c, 600);
            chk(c, 600);
            wr(`STM_OFS_CMPA_LO, 8'h64);
            duty(8'hAA, 200, 200);
            $display("output pin test done");
        end
    endtask

    task t_flag;
        wr(`STM_OFS_CMPA_HI, 8'h02);
        wr(`STM_OFS_CMPA_LO, 8'h58);
        wr(`STM_OFS_CTRL_A, 8'h00);
        wr(`STM_OFS_STATUS, 8'h03);
        start(8'h01);
        tick(1500);
        wr(`STM_OFS_CTRL_A, 8'h00);
        rd(`STM_OFS_STATUS);
        chk(rdv, 32'h0000_0001);
        wr(`STM_OFS_STATUS, 8'h03);
        rd(`STM_OFS_STATUS);
        chk(rdv, 32'h0000_0000);
        wr(`STM_OFS_CMPA_HI, 8'h00);
        wr(`STM_OFS_CMPA_LO, 8'h64);
        start(8'h00);
        tick(600);
        wr(`STM_OFS_CTRL_A, 8'h00);
        rd(`STM_OFS_STATUS);
        chk(rdv, 32'h0000_0003);
        rd(`STM_OFS_CNT_HI);
        chk(rdv, 32'h0000_0000);
        $display("flag test done");
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_clk();
        t_cnt();
        t_out();
        t_flag();
        wrap_up();
    end
endmodule

`default_nettype wire
